// File: drsup_cpu_model.sv
// Purpose: Processor side of the supervisor: reset and interrupt pins
// Assumes: Undriven pins are pulled up on the board
// Notes:   Resolved pin levels are handed back to the bench
`timescale 1ns/1ns
`default_nettype none
module drsup_cpu_model (
	input  wire logic i_reset_n,
	input  wire logic i_reset_oe,
	input  wire logic i_irq_n,
	input  wire logic i_irq_oe,
	output var  logic o_reset_level,
	output var  logic o_irq_level
);
	// ==========================================================
	// Pin resolution
	// pull-up when released
	always_comb begin
		o_reset_level = i_reset_oe ? i_reset_n : 1'b1;
		o_irq_level   = i_irq_oe ? i_irq_n : 1'b1;
	end
endmodule
`default_nettype wire

// File: drsup_hold_timer.sv
// Purpose: Stretches a hold condition by a fixed timeout
// Assumes: Hold input is synchronous to i_clock
// Notes:   Active out of reset, so outputs start asserted
`timescale 1ns/1ns
`default_nettype none
module drsup_hold_timer #(
	parameter logic [31:0] TIMEOUT = drsup_pkg::RESET_TIMEOUT_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	input  wire logic        i_hold,
	output var  logic        o_active,
	output var  logic [31:0] o_count
);
	logic        next_active;
	logic [31:0] next_count;

	initial begin
		if (TIMEOUT == 32'h0) begin
			$error("drsup_hold_timer: TIMEOUT must be nonzero");
		end
	end

	// ==========================================================
	// Counter
	always_comb begin
		next_active = o_active;
		next_count  = o_count;
		if (i_hold) begin
			next_active = 1'b1;
			next_count  = 32'h0;
		end else if (o_active) begin
			if (o_count == TIMEOUT - 32'h1) begin
				next_active = 1'b0;
				next_count  = 32'h0;
			end else begin
				next_count = o_count + 32'h1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_active <= 1'b1;
			o_count  <= 32'h0;
		end else begin
			o_active <= next_active;
			o_count  <= next_count;
		end
	end
endmodule
`default_nettype wire

// File: drsup_pkg.sv
// Purpose: Shared constants of the dual output reset supervisor
// Assumes: 250 MHz block clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package drsup_pkg;
	// ==========================================================
	// Clock
	localparam longint CLOCK_HZ = 250_000_000;

	// ==========================================================
	// Timeouts in milliseconds
	localparam longint RESET_TIMEOUT_MS     = 140;
	localparam longint RESET_TIMEOUT_MAX_MS = 280;
	localparam longint SETUP_0_MS           = 10080;
	localparam longint SETUP_1_MS           = 6720;
	localparam longint SETUP_2_MS           = 3360;
	localparam longint SETUP_3_MS           = 1680;

	// ==========================================================
	// Cycle counts, least times rounded up
	localparam logic [31:0] RESET_TIMEOUT_CYCLES = 32'((CLOCK_HZ * RESET_TIMEOUT_MS + 999) / 1000);
	localparam logic [31:0] RESET_TIMEOUT_MAX_CYCLES = 32'((CLOCK_HZ * RESET_TIMEOUT_MAX_MS) / 1000);
	localparam logic [31:0] SETUP_0_CYCLES = 32'((CLOCK_HZ * SETUP_0_MS + 999) / 1000);
	localparam logic [31:0] SETUP_1_CYCLES = 32'((CLOCK_HZ * SETUP_1_MS + 999) / 1000);
	localparam logic [31:0] SETUP_2_CYCLES = 32'((CLOCK_HZ * SETUP_2_MS + 999) / 1000);
	localparam logic [31:0] SETUP_3_CYCLES = 32'((CLOCK_HZ * SETUP_3_MS + 999) / 1000);

	// ==========================================================
	// Reset values
	localparam logic SYNC_SUPPLY_RESET = 1'b0;
	localparam logic SYNC_BUTTON_RESET = 1'b1;
	localparam logic OUT_LEVEL_RESET   = 1'b0;
	localparam logic OUT_OE_RESET      = 1'b1;
endpackage

// File: drsup_top.sv
// Purpose: Timing logic of a supervisor with system and soft reset outputs
// Assumes: Comparator results and pushbutton arrive asynchronously
// Notes:   Analog thresholds and pin drive strength live outside
`timescale 1ns/1ns
`default_nettype none
module drsup_top #(
	parameter bit               EXTENDED_SETUP       = 1'b1,
	parameter bit               OPEN_DRAIN           = 1'b0,
	parameter logic [1:0]       SETUP_SEL            = 2'h0,
	parameter logic [31:0]      RESET_TIMEOUT_CYCLES = drsup_pkg::RESET_TIMEOUT_CYCLES,
	parameter logic [3:0][31:0] SETUP_CYCLES         = {drsup_pkg::SETUP_3_CYCLES, drsup_pkg::SETUP_2_CYCLES,
	                                                    drsup_pkg::SETUP_1_CYCLES, drsup_pkg::SETUP_0_CYCLES}
) (
	input  wire logic i_clock,
	input  wire logic i_arst_n,
	input  wire logic i_vcc_sense,
	input  wire logic i_aux_voltage_sense,
	input  wire logic i_pushbutton_in_n,
	output var  logic o_system_reset_n,
	output var  logic o_system_reset_oe,
	output var  logic o_soft_reset_out_n,
	output var  logic o_soft_reset_out_oe
);
	localparam logic [31:0] SETUP_LIMIT = SETUP_CYCLES[SETUP_SEL];
	localparam int          SYNC_DELAY  = 2;

	// ==========================================================
	// Elaboration checks
	initial begin
		// Timeout range check
		// min and max
		if (RESET_TIMEOUT_CYCLES == 32'h0 || RESET_TIMEOUT_CYCLES > drsup_pkg::RESET_TIMEOUT_MAX_CYCLES) begin
			$error("drsup_top: reset timeout outside its allowed range");
		end
		if (SETUP_LIMIT == 32'h0) begin
			$error("drsup_top: setup period must be nonzero");
		end
	end

	// ==========================================================
	// Input synchronisers
	logic [1:0] vcc_sync;
	logic [1:0] aux_sync;
	logic [1:0] btn_sync;
	logic [1:0] next_vcc_sync;
	logic [1:0] next_aux_sync;
	logic [1:0] next_btn_sync;

	// Two stages per input
	// sync chains
	always_comb begin
		next_vcc_sync = {vcc_sync[0], i_vcc_sense};
		next_aux_sync = {aux_sync[0], i_aux_voltage_sense};
		next_btn_sync = {btn_sync[0], i_pushbutton_in_n};
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			vcc_sync <= {2{drsup_pkg::SYNC_SUPPLY_RESET}};
			aux_sync <= {2{drsup_pkg::SYNC_SUPPLY_RESET}};
			btn_sync <= {2{drsup_pkg::SYNC_BUTTON_RESET}};
		end else begin
			vcc_sync <= next_vcc_sync;
			aux_sync <= next_aux_sync;
			btn_sync <= next_btn_sync;
		end
	end

	logic supply_bad;
	logic btn_low;

	// Either comparator low
	// supply fault
	assign supply_bad = !vcc_sync[1] || !aux_sync[1];
	assign btn_low    = !btn_sync[1];

	// ==========================================================
	// Long press detector
	logic [31:0] press_count;
	logic        long_press;
	logic [31:0] next_press_count;
	logic        next_long_press;

	// Saturating count, cleared on release
	// setup period
	always_comb begin
		next_press_count = 32'h0;
		next_long_press  = 1'b0;
		if (btn_low && EXTENDED_SETUP) begin
			next_long_press  = long_press || (press_count == SETUP_LIMIT - 32'h1);
			next_press_count = (press_count == SETUP_LIMIT - 32'h1) ? press_count : press_count + 32'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			press_count <= 32'h0;
			long_press  <= 1'b0;
		end else begin
			press_count <= next_press_count;
			long_press  <= next_long_press;
		end
	end

	// ==========================================================
	// Timeout stretchers
	logic        sys_hold;
	logic        sys_active;
	logic [31:0] sys_count;
	logic        soft_active;
	logic [31:0] soft_count;

	// Button only joins in the extended variant
	// isolation
	assign sys_hold = supply_bad || (EXTENDED_SETUP && long_press);

	// Release after the timeout
	// supply timeout
	drsup_hold_timer #(
		.TIMEOUT (RESET_TIMEOUT_CYCLES)
	) u_sys_timer (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_hold   (sys_hold),
		.o_active (sys_active),
		.o_count  (sys_count)
	);

	// No setup delay here
	// immediate soft reset
	drsup_hold_timer #(
		.TIMEOUT (RESET_TIMEOUT_CYCLES)
	) u_soft_timer (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_hold   (btn_low),
		.o_active (soft_active),
		.o_count  (soft_count)
	);

	// ==========================================================
	// Output drive
	logic next_system_reset_n;
	logic next_system_reset_oe;
	logic next_soft_reset_out_n;
	logic next_soft_reset_out_oe;

	// Open-drain only pulls low, floats otherwise
	// drive style
	always_comb begin
		if (OPEN_DRAIN) begin
			next_system_reset_n    = 1'b0;
			next_system_reset_oe   = sys_active;
			next_soft_reset_out_n  = 1'b0;
			next_soft_reset_out_oe = soft_active;
		end else begin
			next_system_reset_n    = !sys_active;
			next_system_reset_oe   = 1'b1;
			next_soft_reset_out_n  = !soft_active;
			next_soft_reset_out_oe = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_system_reset_n    <= drsup_pkg::OUT_LEVEL_RESET;
			o_system_reset_oe   <= drsup_pkg::OUT_OE_RESET;
			o_soft_reset_out_n  <= drsup_pkg::OUT_LEVEL_RESET;
			o_soft_reset_out_oe <= drsup_pkg::OUT_OE_RESET;
		end else begin
			o_system_reset_n    <= next_system_reset_n;
			o_system_reset_oe   <= next_system_reset_oe;
			o_soft_reset_out_n  <= next_soft_reset_out_n;
			o_soft_reset_out_oe <= next_soft_reset_out_oe;
		end
	end

	// ==========================================================
	// Assertions
	logic sys_pin_low;
	logic soft_pin_low;

	assign sys_pin_low  = o_system_reset_oe && !o_system_reset_n;
	assign soft_pin_low = o_soft_reset_out_oe && !o_soft_reset_out_n;

	sequence s_press_done;
		EXTENDED_SETUP && btn_low && (press_count == SETUP_LIMIT - 32'h1);
	endsequence

	sequence s_sys_pin_low_2;
		##SYNC_DELAY sys_pin_low;
	endsequence

	property p_supply_assert;
		@(posedge i_clock) disable iff (!i_arst_n)
		supply_bad |-> s_sys_pin_low_2;
	endproperty
	a_supply_assert: assert property (p_supply_assert) else $error("supply fault did not pull system reset");

	property p_sys_release;
		@(posedge i_clock) disable iff (!i_arst_n)
		$fell(sys_active) |-> ($past(sys_count) == RESET_TIMEOUT_CYCLES - 32'h1) && !$past(sys_hold);
	endproperty
	a_sys_release: assert property (p_sys_release) else $error("system reset released at wrong count");

	property p_button_isolated;
		@(posedge i_clock) disable iff (!i_arst_n)
		!EXTENDED_SETUP |-> (sys_hold == supply_bad);
	endproperty
	a_button_isolated: assert property (p_button_isolated) else $error("button reached system reset");

	property p_long_press;
		@(posedge i_clock) disable iff (!i_arst_n)
		s_press_done |=> long_press ##1 sys_active ##1 sys_pin_low;
	endproperty
	a_long_press: assert property (p_long_press) else $error("long press did not assert system reset");

	property p_long_press_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		$fell(long_press) |-> sys_active && (sys_count == 32'h0);
	endproperty
	a_long_press_hold: assert property (p_long_press_hold) else $error("timeout not restarted at release");

	property p_soft_immediate;
		@(posedge i_clock) disable iff (!i_arst_n)
		btn_low |-> ##2 soft_pin_low;
	endproperty
	a_soft_immediate: assert property (p_soft_immediate) else $error("soft reset not immediate");

	property p_soft_release;
		@(posedge i_clock) disable iff (!i_arst_n)
		$fell(soft_active) |-> ($past(soft_count) == RESET_TIMEOUT_CYCLES - 32'h1) && !$past(btn_low);
	endproperty
	a_soft_release: assert property (p_soft_release) else $error("soft reset released at wrong count");

	property p_open_drain;
		@(posedge i_clock) disable iff (!i_arst_n)
		OPEN_DRAIN |-> !o_system_reset_n && !o_soft_reset_out_n;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain output drove high");

	property p_setup_limit;
		@(posedge i_clock) disable iff (!i_arst_n)
		$rose(long_press) |-> $past(press_count) == SETUP_LIMIT - 32'h1;
	endproperty
	a_setup_limit: assert property (p_setup_limit) else $error("long press at wrong setup count");
endmodule
`default_nettype wire

// File: drsup_top_test.sv
// Purpose: Self-checking bench of the supervisor timing logic
// Assumes: Short timeouts stand in for the real ones
// Notes:   Pin 0/1 extended build, pin 2/3 plain open-drain build
`timescale 1ns/1ns
`default_nettype none
module drsup_top_test;
	// ==========================================================
	// Stimulus and pins
	localparam int T = 20;
	localparam int S = 20;
	logic       i_clock = 1'b0;
	logic       i_arst_n = 1'b0;
	logic       vcc = 1'b1;
	logic       aux = 1'b1;
	logic       btn_n = 1'b1;
	wire logic [3:0] rn, oe, pins;
	int         err_total = 0;
	int         checks = 0;
	int         n;

	initial begin
		forever #2 i_clock = ~i_clock;
	end

	drsup_top #(.RESET_TIMEOUT_CYCLES(32'h14), .SETUP_SEL(2'h1),
		.SETUP_CYCLES({32'h28, 32'h1e, 32'h14, 32'h0a})) u_drsup_top (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_vcc_sense(vcc), .i_aux_voltage_sense(aux),
		.i_pushbutton_in_n(btn_n), .o_system_reset_n(rn[0]), .o_system_reset_oe(oe[0]),
		.o_soft_reset_out_n(rn[1]), .o_soft_reset_out_oe(oe[1]));
	// Plain build shares every input, so no stimulus is duplicated
	drsup_top #(.EXTENDED_SETUP(1'b0), .OPEN_DRAIN(1'b1), .RESET_TIMEOUT_CYCLES(32'h14)) u_drsup_top_plain (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_vcc_sense(vcc), .i_aux_voltage_sense(aux),
		.i_pushbutton_in_n(btn_n), .o_system_reset_n(rn[2]), .o_system_reset_oe(oe[2]),
		.o_soft_reset_out_n(rn[3]), .o_soft_reset_out_oe(oe[3]));
	drsup_cpu_model u_cpu_ext (.i_reset_n(rn[0]), .i_reset_oe(oe[0]), .i_irq_n(rn[1]), .i_irq_oe(oe[1]),
		.o_reset_level(pins[0]), .o_irq_level(pins[1]));
	drsup_cpu_model u_cpu_plain (.i_reset_n(rn[2]), .i_reset_oe(oe[2]), .i_irq_n(rn[3]), .i_irq_oe(oe[3]),
		.o_reset_level(pins[2]), .o_irq_level(pins[3]));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Cycles until a pin reaches a level, bounded
	task automatic wait_pin(input int idx, input logic lvl, input int max, output int cnt);
		cnt = 0;
		do begin
			@(posedge i_clock);
			#1;
			cnt++;
		end while (pins[idx] !== lvl && cnt < max);
	endtask

	task automatic hold(input int cyc);
		repeat (cyc) @(posedge i_clock);
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_power_up();
		// Outputs asserted while reset is held
		check(32'(pins), 32'h0);
		@(posedge i_clock);
		i_arst_n <= 1'b1;
		wait_pin(0, 1'b1, T + 10, n);
		check(32'(n >= T && n <= T + 6), 32'h1);
		hold(3);
		#1;
		check(32'(pins), 32'hf);
		check(32'(oe[3:2]), 32'h0);
		check(32'(oe[1:0]), 32'h3);
		$display("Test power_up done");
	endtask

	// Source 0 dips the primary supply, source 1 the adjustable input
	task automatic t_supply_dip(input int src);
		@(posedge i_clock);
		if (src == 0) vcc <= 1'b0;
		else aux <= 1'b0;
		wait_pin(0, 1'b0, 8, n);
		check(32'(n <= 4), 32'h1);
		#1;
		check(32'({pins[2], pins[3], pins[1]}), 32'h3);
		check(32'(oe[2]), 32'h1);
		hold(6);
		vcc <= 1'b1;
		aux <= 1'b1;
		wait_pin(2, 1'b1, T + 10, n);
		check(32'(n >= T && n <= T + 6), 32'h1);
		#1;
		check(32'(pins[0]), 32'h1);
		$display("Test supply_dip %0d done", src);
	endtask

	task automatic t_short_press();
		@(posedge i_clock);
		btn_n <= 1'b0;
		wait_pin(1, 1'b0, 8, n);
		check(32'(n <= 4), 32'h1);
		#1;
		check(32'(pins[3]), 32'h0);
		hold(S - 8);
		#1;
		check(32'({pins[0], pins[2]}), 32'h3);
		@(posedge i_clock);
		btn_n <= 1'b1;
		wait_pin(3, 1'b1, T + 10, n);
		check(32'(n >= T && n <= T + 6), 32'h1);
		#1;
		check(32'({pins[0], pins[1]}), 32'h3);
		$display("Test short_press done");
	endtask

	task automatic t_long_press();
		@(posedge i_clock);
		btn_n <= 1'b0;
		wait_pin(0, 1'b0, S + 10, n);
		check(32'(n >= S && n <= S + 6), 32'h1);
		hold(10);
		#1;
		check(32'(pins[2]), 32'h1);
		@(posedge i_clock);
		btn_n <= 1'b1;
		wait_pin(0, 1'b1, T + 10, n);
		check(32'(n >= T && n <= T + 6), 32'h1);
		#1;
		check(32'(pins[1]), 32'h1);
		$display("Test long_press done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		hold(5);
		t_power_up();
		t_supply_dip(0);
		t_supply_dip(1);
		t_short_press();
		t_long_press();
		conclude();
	end

	// Run needs about two hundred cycles; twenty-five times that is a hang
	initial begin
		hold(5000);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
